// ==== core/swrp_write_path.sv ====
// delayed write path into the two slow-clock power management registers
`timescale 1ns/1ns
module swrp_write_path
	import swrp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic bus_wr,
	input wire logic bus_wr_sel,
	input wire logic [SWRP_DW-1:0] bus_wr_data,
	output logic bus_wr_ready,
	input wire logic bus_rd,
	input wire logic bus_rd_sel,
	output logic [SWRP_DW-1:0] bus_rd_data,
	output logic bus_rd_valid,
	input wire logic short_event,
	input wire logic [SWRP_FAIL_N-1:0] fail_event,
	output logic supply_en,
	output logic short_flag,
	output logic [SWRP_FAIL_N-1:0] fail_flags
);
	logic mi_tick;

	swrp_mi_div u_div (
		.mclk(mclk),
		.rst(rst),
		.mi_tick(mi_tick)
	);

	// event inputs come from analog monitors, so they are synchronised first
	logic [SWRP_FAIL_N:0] ev_meta_reg;
	logic [SWRP_FAIL_N:0] ev_sync_reg;
	// events are caught between ticks so a short pulse is not missed
	logic [SWRP_FAIL_N:0] ev_seen_reg;
	logic [SWRP_FAIL_N:0] ev_seen_next;

	// in-order pending writes, entry 0 is the oldest
	logic q_sel_reg [SWRP_DEPTH];
	logic q_sel_next [SWRP_DEPTH];
	logic [SWRP_DW-1:0] q_data_reg [SWRP_DEPTH];
	logic [SWRP_DW-1:0] q_data_next [SWRP_DEPTH];
	logic [SWRP_CW-1:0] cnt_reg;
	logic [SWRP_CW-1:0] cnt_next;
	logic ready_reg;
	logic ready_next;

	logic [SWRP_DW-1:0] supply_reg;
	logic [SWRP_DW-1:0] supply_next;
	logic [SWRP_DW-1:0] fail_reg;
	logic [SWRP_DW-1:0] fail_next;
	logic [SWRP_DW-1:0] rd_data_reg;
	logic [SWRP_DW-1:0] rd_data_next;
	logic rd_valid_reg;
	logic rd_valid_next;

	logic accept;
	logic apply;
	logic [SWRP_CW-1:0] cnt_after_apply;
	logic [SWRP_DW-1:0] set_supply;
	logic [SWRP_DW-1:0] set_fail;

	// write-one-to-clear; a zero in a flag bit has no effect
	function automatic logic [SWRP_DW-1:0] swrp_w1c(
		input logic [SWRP_DW-1:0] data,
		input logic [SWRP_DW-1:0] mask
	);
		swrp_w1c = data & mask;
	endfunction

	// one landed write: rw bits take the data, w1c bits clear on a one
	// the hardware set is or-ed in last, so a set in the clearing tick wins
	function automatic logic [SWRP_DW-1:0] swrp_land(
		input logic [SWRP_DW-1:0] cur,
		input logic [SWRP_DW-1:0] data,
		input logic [SWRP_DW-1:0] rw_mask,
		input logic [SWRP_DW-1:0] w1c_mask,
		input logic [SWRP_DW-1:0] set
	);
		logic [SWRP_DW-1:0] tmp;
		tmp = (cur & ~rw_mask) | (data & rw_mask);
		swrp_land = (tmp & ~swrp_w1c(data, w1c_mask)) | set;
	endfunction

	// synchroniser: only the second stage is read by logic
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ev_meta_reg <= '0;
			ev_sync_reg <= '0;
		end else begin
			ev_meta_reg <= {short_event, fail_event};
			ev_sync_reg <= ev_meta_reg;
		end
	end

	always_comb begin
		ev_seen_next = ev_seen_reg | ev_sync_reg;
		if (mi_tick) begin
			ev_seen_next = ev_sync_reg;
		end
	end

	// the catch register restarts on a tick, the flags keep the event from then on
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ev_seen_reg <= '0;
		end else begin
			ev_seen_reg <= ev_seen_next;
		end
	end

	// writes wait here for the slow tick; a read never waits, so a read issued
	// before a pending clear lands sees the old flag
	always_comb begin
		accept = bus_wr && ready_reg;
		apply = mi_tick && (cnt_reg != '0); // [R1]
		cnt_after_apply = apply ? cnt_reg - 1'b1 : cnt_reg;
		cnt_next = accept ? cnt_after_apply + 1'b1 : cnt_after_apply;
		// only an empty queue takes a write, so a second write waits until the first has landed
		// and a read after it sees the first; this costs throughput, not correctness
		ready_next = (cnt_next == '0); // [R6]
		for (int i = 0; i < SWRP_DEPTH; i++) begin
			q_sel_next[i] = q_sel_reg[i];
			q_data_next[i] = q_data_reg[i];
		end
		if (apply) begin
			// one write lands per tick, oldest first
			for (int i = 0; i < SWRP_DEPTH - 1; i++) begin
				q_sel_next[i] = q_sel_reg[i + 1]; // [R8]
				q_data_next[i] = q_data_reg[i + 1]; // [R6]
			end
		end
		if (accept) begin
			q_sel_next[cnt_after_apply[0]] = bus_wr_sel; // [R8]
			q_data_next[cnt_after_apply[0]] = bus_wr_data;
		end
	end

	// queue state, reset to empty and ready
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			ready_reg <= 1'b1;
			for (int i = 0; i < SWRP_DEPTH; i++) begin
				q_sel_reg[i] <= 1'b0;
				q_data_reg[i] <= '0;
			end
		end else begin
			cnt_reg <= cnt_next;
			ready_reg <= ready_next;
			for (int i = 0; i < SWRP_DEPTH; i++) begin
				q_sel_reg[i] <= q_sel_next[i];
				q_data_reg[i] <= q_data_next[i];
			end
		end
	end

	// the two slow-clock registers change only on a tick
	// trade-off: a set and a clear in one tick keep the flag, so no event is lost
	always_comb begin
		set_supply = '0;
		set_fail = '0;
		// flags are set only on a slow tick, as the registers live in that domain
		set_supply[SWRP_SHORT_BIT] = mi_tick && ev_seen_reg[SWRP_FAIL_N];
		set_fail[SWRP_FAIL_N-1:0] = mi_tick ? ev_seen_reg[SWRP_FAIL_N-1:0] : '0;
		// no write landing: only sets can change the flags
		supply_next = supply_reg | set_supply;
		fail_next = fail_reg | set_fail;
		if (apply && (q_sel_reg[0] == SWRP_SEL_SUPPLY)) begin // [R2]
			supply_next = swrp_land(supply_reg, q_data_reg[0], SWRP_SUPPLY_RW_MASK,
				SWRP_SUPPLY_W1C_MASK, set_supply); // [R3] [R5]
		end
		if (apply && (q_sel_reg[0] == SWRP_SEL_FAIL)) begin // [R2]
			fail_next = swrp_land(fail_reg, q_data_reg[0], '0, SWRP_FAIL_W1C_MASK, set_fail); // [R5]
		end
	end

	// each register has its own flop group
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			supply_reg <= SWRP_SUPPLY_RST;
		end else begin
			supply_reg <= supply_next;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fail_reg <= SWRP_FAIL_RST;
		end else begin
			fail_reg <= fail_next;
		end
	end

	// read port
	always_comb begin
		// reads see the landed value only, pending writes are not forwarded
		rd_data_next = rd_data_reg;
		if (bus_rd) begin
			rd_data_next = (bus_rd_sel == SWRP_SEL_FAIL) ? fail_reg : supply_reg; // [R4]
		end
		// valid is a one-cycle pulse in the cycle after the request
		rd_valid_next = bus_rd;
	end

	// read data holds until the next read
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_data_reg <= '0;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	// outputs straight from the registers
	assign bus_wr_ready = ready_reg;
	assign bus_rd_data = rd_data_reg;
	assign bus_rd_valid = rd_valid_reg;
	assign supply_en = supply_reg[SWRP_SUPPLY_EN_BIT];
	assign short_flag = supply_reg[SWRP_SHORT_BIT];
	assign fail_flags = fail_reg[SWRP_FAIL_N-1:0];
endmodule // swrp_write_path

// ==== pkg/swrp_pkg.sv ====
// constants for the slow clock register write path
// How it works
// [R1] a bus write lands in its register on the first slow-clock tick after issue
// [R2] the delayed path serves the supply control and the system fail status registers
// [R3] writing 1 to the short flag clears it once the write has landed
// [R4] reads are served at once, so an unlanded clear may read the old flag
// [R5] writing 0 to a flag bit leaves that register's function unchanged
// [R6] each queued write costs one slow tick, so a zero write delays the next write
// [R7] one instruction between clear and read is too little delay; the read may still see the old flag
// [R8] delayed writes land strictly in the order they were issued
package swrp_pkg;
	localparam int SWRP_DW = 8;
	localparam int SWRP_DEPTH = 2;
	localparam int SWRP_CW = 2;
	// mclk cycles per measurement interface clock cycle
	localparam int SWRP_MI_DIV = 8;
	localparam int SWRP_DIVW = 3;
	localparam logic SWRP_SEL_SUPPLY = 1'h0;
	localparam logic SWRP_SEL_FAIL = 1'h1;
	localparam int SWRP_SUPPLY_EN_BIT = 0;
	localparam int SWRP_SHORT_BIT = 1;
	localparam int SWRP_FAIL_N = 4;
	localparam logic [SWRP_DW-1:0] SWRP_SUPPLY_RST = 8'h00;
	localparam logic [SWRP_DW-1:0] SWRP_FAIL_RST = 8'h00;
	localparam logic [SWRP_DW-1:0] SWRP_SUPPLY_RW_MASK = 8'h01;
	localparam logic [SWRP_DW-1:0] SWRP_SUPPLY_W1C_MASK = 8'h02;
	localparam logic [SWRP_DW-1:0] SWRP_FAIL_W1C_MASK = 8'h0F;
endpackage

// ==== core/swrp_mi_div.sv ====
// divider that makes the measurement interface clock tick
`timescale 1ns/1ns
module swrp_mi_div
	import swrp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	output logic mi_tick
);
	logic [SWRP_DIVW-1:0] cnt_reg;
	logic [SWRP_DIVW-1:0] cnt_next;
	logic tick_reg;
	logic tick_next;

	always_comb begin
		tick_next = (cnt_reg == SWRP_DIVW'(SWRP_MI_DIV - 1));
		cnt_next = tick_next ? '0 : cnt_reg + 1'b1;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign mi_tick = tick_reg;
endmodule // swrp_mi_div

// ==== testbench/swrp_write_path_chk.sv ====
// port checker for the write path
`timescale 1ns/1ns
module swrp_chk
	import swrp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic bus_wr,
	input wire logic bus_wr_sel,
	input wire logic bus_wr_ready,
	input wire logic bus_rd,
	input wire logic bus_rd_valid,
	input wire logic short_event,
	input wire logic supply_en,
	input wire logic short_flag,
	input wire logic [SWRP_DW-1:0] bus_wr_data,
	input wire logic [SWRP_FAIL_N-1:0] fail_flags
);
	wire logic ws = bus_wr && bus_wr_ready && !bus_wr_sel;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// 17 cycles cover two slow ticks; an accepted write never waits behind another and lands on the first
	a_rd_answer: assert property (bus_rd |=> bus_rd_valid) else $error("no answer");
	a_valid_pulse: assert property (!bus_rd |=> !bus_rd_valid) else $error("stray valid");
	a_clear_lands: assert property (ws && bus_wr_data[1] && !short_event
		|-> ##[1:17] !short_flag) else $error("clear lost");
	a_en_lands: assert property (ws && bus_wr_data[0] |-> ##[1:17] supply_en)
		else $error("enable lost");
	a_fail_clear: assert property (bus_wr && bus_wr_ready && bus_wr_sel && bus_wr_data[0]
		|-> ##[1:17] !fail_flags[0]) else $error("fail clear lost");
	a_ready_rst: assert property ($past(rst) |-> bus_wr_ready) else $error("not ready");
	a_ready_drop: assert property (bus_wr && bus_wr_ready |=> !bus_wr_ready)
		else $error("second write taken early");
endmodule // swrp_chk
bind swrp_write_path swrp_chk chk (.mclk, .rst, .bus_wr, .bus_wr_sel, .bus_wr_ready, .bus_rd,
	.bus_rd_valid, .short_event, .supply_en, .short_flag, .bus_wr_data, .fail_flags);

// ==== testbench/swrp_cpu_model.sv ====
// bus master model
`timescale 1ns/1ns
module swrp_cpu_model
	import swrp_pkg::*;
(
	input wire logic mclk,
	input wire logic bus_wr_ready,
	input wire logic bus_rd_valid,
	input wire logic [SWRP_DW-1:0] bus_rd_data,
	output logic bus_wr,
	output logic bus_wr_sel,
	output logic bus_rd,
	output logic bus_rd_sel,
	output logic [SWRP_DW-1:0] bus_wr_data
);
	initial begin
		{bus_wr, bus_wr_sel, bus_rd, bus_rd_sel, bus_wr_data} = 12'h000;
	end
	// request holds until ready is seen at an edge; the strobe then drops for one edge
	// so the same word is never taken twice
	task automatic wr(input logic s, input logic [7:0] x, output logic [7:0] ok);
		int n;
		n = 0;
		ok = 8'h00;
		{bus_wr, bus_wr_sel, bus_wr_data} <= {1'h1, s, x};
		do begin
			@(negedge mclk) ok = 8'(bus_wr_ready);
			@(posedge mclk) n++;
		end while (ok == 8'h00 && n < 40);
		bus_wr <= 1'h0;
		@(posedge mclk);
	endtask
	// a released data bus shows the inverse of its current value, so a second release restores the last write
	task automatic rd(logic s, output logic [7:0] q, v);
		{bus_wr, bus_rd, bus_rd_sel, bus_wr_data} <= {2'h1, s, ~bus_wr_data};
		@(posedge mclk) bus_rd <= 1'h0;
		@(negedge mclk) v = 8'(bus_rd_valid);
		q = bus_rd_data;
		@(posedge mclk);
	endtask
	task automatic idle;
		{bus_wr, bus_wr_data} <= {1'h0, ~bus_wr_data};
		@(posedge mclk);
	endtask
endmodule // swrp_cpu_model

// ==== testbench/swrp_write_path_tb.sv ====
// write path testbench
`timescale 1ns/1ns
module swrp_write_path_tb import swrp_pkg::*;;
	logic mclk, rst, short_event, bus_wr, bus_wr_sel, bus_wr_ready, bus_rd, bus_rd_sel;
	logic bus_rd_valid, supply_en, short_flag;
	logic [7:0] bus_wr_data, bus_rd_data, d, v, ok;
	logic [3:0] fail_event, fail_flags;
	int num_errors = 0;
	int samples_checked = 0;
	swrp_write_path dut (.mclk, .rst, .bus_wr, .bus_wr_sel, .bus_wr_data, .bus_wr_ready, .bus_rd,
		.bus_rd_sel, .bus_rd_data, .bus_rd_valid, .short_event, .fail_event, .supply_en,
		.short_flag, .fail_flags);
	swrp_cpu_model cpu (.mclk, .bus_wr_ready, .bus_rd_valid, .bus_rd_data, .bus_wr, .bus_wr_sel,
		.bus_rd, .bus_rd_sel, .bus_wr_data);
	task automatic check(string n, logic [7:0] s, e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic w(logic s, logic [7:0] x);
		cpu.wr(s, x, ok);
		check("taken", ok, 8'h01);
		if (ok !== 8'h01)
			finish_test();
	endtask
	task automatic r(logic s, logic [7:0] e);
		cpu.rd(s, d, v);
		check("valid", v, 8'h01);
		check("data", d, e);
	endtask
	task automatic pause;
		cpu.idle();
		repeat (20) @(posedge mclk);
	endtask
	// events pass a synchroniser, so hold them a few cycles
	task automatic ev(logic s, logic [3:0] f);
		{short_event, fail_event} <= {s, f};
		repeat (4) @(posedge mclk);
		{short_event, fail_event} <= 5'h00;
		pause();
	endtask
	task automatic sc_clear;
		ev(1'h1, 4'h0);
		w(1'h0, 8'h02);
		cpu.rd(1'h0, d, v);
		repeat (9) @(posedge mclk);
		r(1'h0, 8'h00);
		check("short", 8'(short_flag), 8'h00);
	endtask
	task automatic sc_zero;
		ev(1'h1, 4'h0);
		w(1'h0, 8'h00);
		pause();
		r(1'h0, 8'h02);
	endtask
	task automatic sc_order;
		w(1'h0, 8'h03);
		w(1'h0, 8'h01);
		r(1'h0, 8'h01);
		w(1'h0, 8'h00);
		w(1'h0, 8'h01);
		pause();
		check("enable", 8'(supply_en), 8'h01);
	endtask
	task automatic sc_fail;
		ev(1'h0, 4'hF);
		w(1'h1, 8'h05);
		pause();
		r(1'h1, 8'h0A);
		check("fail flags", 8'(fail_flags), 8'h0A);
	endtask
	initial begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		rst = 1'h1;
		{short_event, fail_event} = 5'h00;
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		check("ready", 8'(bus_wr_ready), 8'h01);
		sc_clear();
		sc_zero();
		sc_order();
		sc_fail();
		finish_test();
	end
endmodule // swrp_write_path_tb
